// ===== hdl/nvm_access_pkg.sv
// Package: register map, field layout, op-codes, timing for the EEPROM access block
package nvm_access_pkg;
    localparam logic [7:0] ADDR_NVM_ACCESS = 8'h00;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
    localparam logic [7:0] ADDR_CONTROL = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_CONFIG = 8'h14;
    // Access register layout: [31:24] op-code, [23] busy, [22:16] address, [15:0] data
    localparam int OPC_LSB = 24;
    localparam int BUSY_BIT = 23;
    localparam int ADR_LSB = 16;
    localparam int ADR_W = 7;
    localparam int DAT_W = 16;
    localparam int NVM_WORDS = 128;
    localparam logic [7:0] OPC_READ = 8'h01;
    localparam logic [7:0] OPC_WRITE = 8'h02;
    // Interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERROR = 1;
    localparam int IRQ_TRIGGER = 2;
    localparam int IRQ_W = 3;
    // Control bits
    localparam int CTL_EXTERNAL_TIMEBASE_MODE = 0;
    localparam int CTL_SWTRIG = 1;
    localparam int CTL_RELOAD = 2;
    localparam logic [2:0] CONTROL_RESET = 3'h0;
    // Timing at 20 MHz
    localparam int CLK_HZ = 20000000;
    localparam int NVM_READ_NS = 1000;
    localparam int NVM_WRITE_US = 100;
    localparam int READ_CYCLES = (NVM_READ_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int WRITE_CYCLES = NVM_WRITE_US * (CLK_HZ / 1000000);
    localparam int EXTERNAL_TIMEBASE_MODE_JITTER = 96;
    localparam int CNT_W = 12;
endpackage : nvm_access_pkg

// ===== hdl/nvm_access_trigger.sv
// Module: EEPROM access path, configuration load and measurement trigger
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - Writing an op-code into byte 3 of access register starts the access.
// - Configuration is loaded from the internal EEPROM, not from pins.
// - EEPROM is programmed only through the AXI4-Lite host interface.
// - External_timebase_mode external time base: sampling jitters up to 96 periods.
// - Devices sharing an external time base do not sample in synchronism; each waits on its own free counter.
// - In synchronous mode the trigger pin still serves asynchronous triggers.
// - Transfer-enable/trigger pin controls when simple master transfers occur.
// - An optional output reports ready or error state to the host.
module nvm_access_trigger (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Pins
    input wire logic transfer_enable_trigger_pin_i,
    output logic measure_strobe_o,
    output logic transfer_window_o,
    output logic ready_error_n_o,
    output logic irq_o
);
    import nvm_access_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_READ = 4'b0010,
        ST_WRITE = 4'b0100,
        ST_LOAD = 4'b1000
    } nvm_state_t;

    typedef struct packed {
        nvm_state_t st;
        logic [12:0] wait_cnt;
        logic [7:0] opc;
        logic [ADR_W-1:0] adr;
        logic [DAT_W-1:0] dat;
        logic busy;
        logic [ADR_W-1:0] load_adr;
        logic [DAT_W-1:0] cfg;
        logic cfg_valid;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_mask;
        logic [2:0] ctl;
        logic err;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0] trg_sync;
        logic trg_prev;
        logic [6:0] jit_cnt;
        logic pend;
        logic strobe;
    } state_t;

    state_t q;
    state_t d;
    logic [DAT_W-1:0] mem_q [NVM_WORDS];
    logic mem_we;

    function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : apply_strb

    function automatic logic mapped(input logic [7:0] a);
        return a == ADDR_NVM_ACCESS || a == ADDR_IRQ_STATUS || a == ADDR_IRQ_MASK ||
               a == ADDR_CONTROL || a == ADDR_STATUS || a == ADDR_CONFIG;
    endfunction : mapped

    logic [31:0] acc_word;
    logic [31:0] acc_new;
    logic do_write;
    logic trg_rise;
    logic [IRQ_W-1:0] irq_set;

    always_comb begin
        acc_word = {q.opc, q.busy, q.adr, q.dat};
        acc_new = apply_strb(acc_word, q.wdata, q.wstrb);
        do_write = q.aw_got && q.w_got && !q.bvalid;
        trg_rise = q.trg_sync[1] && !q.trg_prev;
        irq_set = '0;
        mem_we = 1'b0;
        d = q;
        d.strobe = 1'b0;
        // Two flip-flop synchroniser on the trigger pin
        d.trg_sync = {q.trg_sync[0], transfer_enable_trigger_pin_i};
        d.trg_prev = q.trg_sync[1];

        if (s_axi_awvalid_i && !q.aw_got) begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !q.w_got) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata_i;
            d.wstrb = s_axi_wstrb_i;
        end
        if (q.bvalid && s_axi_bready_i) begin
            d.bvalid = 1'b0;
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
        end

        // EEPROM engine
        unique case (q.st)
            ST_IDLE: begin
                d.busy = 1'b0;
            end
            ST_READ, ST_WRITE: begin
                if (q.wait_cnt == '0) begin
                    if (q.st == ST_READ) begin
                        d.dat = mem_q[q.adr];
                    end else begin
                        mem_we = 1'b1;
                    end
                    d.busy = 1'b0;
                    d.opc = '0;
                    d.st = ST_IDLE;
                    irq_set[IRQ_DONE] = 1'b1;
                end else begin
                    d.wait_cnt = q.wait_cnt - 13'd1;
                end
            end
            ST_LOAD: begin
                // The 16-bit config word comes from EEPROM word 0 after reset and on reload
                if (q.wait_cnt == '0) begin
                    d.cfg = mem_q[q.load_adr];
                    d.cfg_valid = 1'b1;
                    d.busy = 1'b0;
                    d.st = ST_IDLE;
                end else begin
                    d.wait_cnt = q.wait_cnt - 13'd1;
                end
            end
        endcase

        if (do_write) begin
            d.bvalid = 1'b1;
            d.bresp = mapped(q.awaddr) ? 2'b00 : 2'b10;
            unique case (q.awaddr)
                ADDR_NVM_ACCESS: begin
                    // A write while busy is ignored; host should poll first
                    if (!q.busy) begin
                        d.adr = acc_new[ADR_LSB +: ADR_W];
                        d.dat = acc_new[DAT_W-1:0];
                        if (q.wstrb[3]) begin
                            d.opc = acc_new[OPC_LSB +: 8];
                            d.wait_cnt = 13'(WRITE_CYCLES - 1);
                            if (acc_new[OPC_LSB +: 8] == OPC_READ) begin
                                d.busy = 1'b1;
                                d.wait_cnt = 13'(READ_CYCLES - 1);
                                d.st = ST_READ;
                            end else if (acc_new[OPC_LSB +: 8] == OPC_WRITE) begin
                                d.busy = 1'b1;
                                d.st = ST_WRITE;
                            end else begin
                                d.err = 1'b1;
                                d.opc = '0;
                                irq_set[IRQ_ERROR] = 1'b1;
                            end
                        end
                    end
                end
                ADDR_IRQ_STATUS: d.irq_st = q.irq_st & ~q.wdata[IRQ_W-1:0];
                ADDR_IRQ_MASK: d.irq_mask = q.wdata[IRQ_W-1:0];
                ADDR_CONTROL: begin
                    d.ctl = q.wdata[2:0];
                    if (q.wdata[CTL_RELOAD] && !q.busy) begin
                        d.busy = 1'b1;
                        d.wait_cnt = 13'(READ_CYCLES - 1);
                        d.st = ST_LOAD;
                    end
                    if (q.wdata[CTL_RELOAD]) begin
                        d.err = 1'b0;
                    end
                end
                default: ;
            endcase
            d.ctl[CTL_RELOAD] = 1'b0;
        end

        // Measurement trigger
        d.pend = q.pend;
        if (q.ctl[CTL_EXTERNAL_TIMEBASE_MODE]) begin
            // Latching to a free counter adds up to 96 periods of jitter
            if (trg_rise) begin
                d.pend = 1'b1;
            end
            d.jit_cnt = (q.jit_cnt == 7'(EXTERNAL_TIMEBASE_MODE_JITTER - 1)) ? '0 : q.jit_cnt + 7'd1;
            if (q.pend && q.jit_cnt == '0) begin
                d.strobe = 1'b1;
                d.pend = 1'b0;
            end
        end else begin
            d.pend = 1'b0;
            d.jit_cnt = '0;
            // Pin edge fires at once, same latency in every device
            if (trg_rise || (do_write && q.awaddr == ADDR_CONTROL && q.wdata[CTL_SWTRIG])) begin
                d.strobe = 1'b1;
            end
        end
        if (d.strobe) begin
            irq_set[IRQ_TRIGGER] = 1'b1;
        end

        // Set wins over a simultaneous clear
        d.irq_st = d.irq_st | irq_set;

        if (s_axi_arvalid_i && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp = mapped(s_axi_araddr_i) ? 2'b00 : 2'b10;
            unique case (s_axi_araddr_i)
                ADDR_NVM_ACCESS: d.rdata = acc_word;
                ADDR_IRQ_STATUS: d.rdata = {29'h0, q.irq_st};
                ADDR_IRQ_MASK: d.rdata = {29'h0, q.irq_mask};
                ADDR_CONTROL: d.rdata = {29'h0, q.ctl};
                ADDR_STATUS: d.rdata = {29'h0, q.cfg_valid, q.err, q.busy};
                ADDR_CONFIG: d.rdata = {16'h0, q.cfg};
                default: d.rdata = 32'h0;
            endcase
        end else if (q.rvalid && s_axi_rready_i) begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '0;
            q.st <= ST_LOAD;
            q.busy <= 1'b1;
            q.wait_cnt <= 13'(READ_CYCLES - 1);
            q.ctl <= CONTROL_RESET;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            mem_q[q.adr] <= q.dat;
        end
    end

    assign s_axi_awready_o = !q.aw_got;
    assign s_axi_wready_o = !q.w_got;
    assign s_axi_bvalid_o = q.bvalid;
    assign s_axi_bresp_o = q.bresp;
    assign s_axi_arready_o = !q.rvalid;
    assign s_axi_rvalid_o = q.rvalid;
    assign s_axi_rdata_o = q.rdata;
    assign s_axi_rresp_o = q.rresp;
    assign measure_strobe_o = q.strobe;
    assign transfer_window_o = q.trg_sync[1];
    assign ready_error_n_o = q.cfg_valid && !q.err && !q.busy;
    assign irq_o = |(q.irq_st & q.irq_mask);

    a_busy_on_launch: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st == ST_IDLE && d.st inside {ST_READ, ST_WRITE}) |=> q.busy)
        else $error("busy not set on launch");
    a_busy_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st == ST_WRITE) |-> q.busy)
        else $error("busy dropped during write");
    a_launch_byte3: assert property (@(posedge clk_i) disable iff (rst_i)
        (do_write && q.awaddr == ADDR_NVM_ACCESS && !q.busy && q.wstrb[3]
         && q.wdata[31:24] == OPC_READ) |=> q.st == ST_READ)
        else $error("read not launched");
    a_no_launch_lane: assert property (@(posedge clk_i) disable iff (rst_i)
        (do_write && q.awaddr == ADDR_NVM_ACCESS && !q.wstrb[3] && q.st == ST_IDLE)
        |=> q.st == ST_IDLE)
        else $error("launch without byte 3");
    a_bad_opcode: assert property (@(posedge clk_i) disable iff (rst_i)
        (do_write && q.awaddr == ADDR_NVM_ACCESS && !q.busy && q.wstrb[3]
         && q.wdata[31:24] != OPC_READ && q.wdata[31:24] != OPC_WRITE) |=> q.err)
        else $error("bad op-code not flagged");
    a_sync_strobe: assert property (@(posedge clk_i) disable iff (rst_i)
        (!q.ctl[CTL_EXTERNAL_TIMEBASE_MODE] && trg_rise) |=> measure_strobe_o)
        else $error("sync trigger not immediate");
    a_external_timebase_mode_jitter: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.ctl[CTL_EXTERNAL_TIMEBASE_MODE] && $rose(q.pend)) |-> ##[0:96] measure_strobe_o)
        else $error("external_timebase_mode trigger late");
    a_ready_out: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st != ST_IDLE) |-> !ready_error_n_o)
        else $error("ready shown while engine runs");
    a_load_done: assert property (@(posedge clk_i) disable iff (rst_i)
        (q.st == ST_LOAD && q.wait_cnt == '0) |=> (q.cfg_valid && q.st == ST_IDLE))
        else $error("config load incomplete");
endmodule : nvm_access_trigger

// ===== verif/trigger_host_model.sv
// Host-side model driving the transfer-enable/trigger pin
`timescale 1ns/1ps
module trigger_host_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench control
    input wire logic fire_i,
    input wire logic [3:0] width_i,
    // Pin
    output logic pin_o
);
    logic [3:0] left_q;
    // Pin idles low so each pulse gives a fresh rising edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            left_q <= 4'h0;
            pin_o <= 1'b0;
        end else if (fire_i) begin
            left_q <= width_i;
            pin_o <= 1'b1;
        end else if (left_q > 4'h1) begin
            left_q <= left_q - 4'h1;
        end else begin
            left_q <= 4'h0;
            pin_o <= 1'b0;
        end
    end
endmodule : trigger_host_model

// ===== verif/tb_nvm_access_trigger.sv
// Self-checking bench for the EEPROM access and trigger block
`timescale 1ns/1ps
module tb_nvm_access_trigger;
    import nvm_access_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic fire = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pin, strobe, window, ready_err_n, irq;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    int fails = 0, check_count = 0, cyc = 0;
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;
    nvm_access_trigger dut (.clk_i(clk_i), .rst_i(rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .transfer_enable_trigger_pin_i(pin), .measure_strobe_o(strobe),
        .transfer_window_o(window), .ready_error_n_o(ready_err_n), .irq_o(irq));
    trigger_host_model host (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
        .width_i(4'h6), .pin_o(pin));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : chk
    task automatic summarize();
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    task automatic timeout(input string msg);
        fails++;
        $display("MISMATCH %0t timeout %s", $time, msg);
        summarize();
    endtask : timeout
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk_i);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (n == 50) timeout("write");
        resp = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rdt(input logic [7:0] a);
        int n;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (arready && arvalid) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (n == 50) timeout("read");
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rdt
    // Polls the busy flag before any new launch, as a careful host must
    task automatic idle();
        int n;
        for (n = 0; n < 1500; n++) begin
            rdt(ADDR_NVM_ACCESS);
            if (rd[BUSY_BIT] === 1'b0) break;
        end
        if (n == 1500) timeout("busy");
    endtask : idle
    task automatic wait_ready();
        int n;
        for (n = 0; n < 40 && ready_err_n !== 1'b1; n++) @(posedge clk_i);
        if (n == 40) timeout("ready");
    endtask : wait_ready
    task automatic t_boot();
        wait_ready();
        chk(32'(ready_err_n), 32'h1, "ready after load");
        rdt(ADDR_STATUS);
        chk(rd & 32'h7, 32'h4, "config loaded");
        rdt(8'h3c);
        chk(32'(resp), 32'h2, "unmapped read");
        chk(rd, 32'h0, "unmapped reads zero");
        wr(8'h3c, 32'h0, 4'hf);
        chk(32'(resp), 32'h2, "unmapped write");
    endtask : t_boot
    task automatic t_nvm();
        int t0;
        wr(ADDR_IRQ_MASK, 32'h7, 4'hf);
        idle();
        wr(ADDR_NVM_ACCESS, {OPC_WRITE, 1'b0, 7'h05, 16'ha5c3}, 4'hf);
        t0 = cyc;
        chk(32'(resp), 32'h0, "launch okay");
        rdt(ADDR_NVM_ACCESS);
        chk(32'(rd[BUSY_BIT]), 32'h1, "busy on launch");
        chk(32'(ready_err_n), 32'h0, "not ready while busy");
        idle();
        chk(32'(cyc - t0 >= WRITE_CYCLES), 32'h1, "busy held");
        chk(32'(irq), 32'h1, "done irq");
        wr(ADDR_IRQ_STATUS, 32'h7, 4'hf);
        wr(ADDR_NVM_ACCESS, {OPC_WRITE, 1'b0, 7'h05, 16'h0000}, 4'h7);
        rdt(ADDR_NVM_ACCESS);
        chk(32'(rd[BUSY_BIT]), 32'h0, "no launch without top byte");
        chk(32'(irq), 32'h0, "done cleared");
        wr(ADDR_NVM_ACCESS, {OPC_READ, 1'b0, 7'h05, 16'h0000}, 4'hf);
        idle();
        chk(rd & 32'hffff, 32'ha5c3, "read back");
        rdt(ADDR_IRQ_STATUS);
        chk(rd & 32'h7, 32'h1, "done after read");
        wr(ADDR_IRQ_STATUS, 32'h7, 4'hf);
    endtask : t_nvm
    task automatic t_bad();
        idle();
        wr(ADDR_NVM_ACCESS, {8'h7f, 1'b0, 7'h01, 16'h0000}, 4'hf);
        rdt(ADDR_IRQ_STATUS);
        chk(rd & 32'h7, 32'h2, "bad code flagged");
        chk(32'(ready_err_n), 32'h0, "error on pin");
        chk(32'(irq), 32'h1, "error irq");
        wr(ADDR_IRQ_MASK, 32'h0, 4'hf);
        rdt(ADDR_IRQ_MASK);
        chk(32'(irq), 32'h0, "irq masked");
        // Word 0 is what the next configuration load must bring in
        wr(ADDR_NVM_ACCESS, {OPC_WRITE, 1'b0, 7'h00, 16'h3c5a}, 4'hf);
        idle();
        wr(ADDR_IRQ_STATUS, 32'h7, 4'hf);
        wr(ADDR_CONTROL, 32'h4, 4'hf);
        repeat (READ_CYCLES) @(posedge clk_i);
        wait_ready();
        rdt(ADDR_STATUS);
        chk(rd & 32'h7, 32'h4, "reload clears error");
        chk(32'(ready_err_n), 32'h1, "ready after reload");
        rdt(ADDR_CONFIG);
        chk(rd, 32'h3c5a, "config from word 0");
    endtask : t_bad
    task automatic t_trig(input logic external_timebase_mode, input int lim);
        int n;
        wr(ADDR_CONTROL, {31'h0, external_timebase_mode}, 4'hf);
        wr(ADDR_IRQ_STATUS, 32'h7, 4'hf);
        @(posedge clk_i);
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        for (n = 0; n < lim && strobe !== 1'b1; n++) @(posedge clk_i);
        chk(32'(n < lim), 32'h1, "strobe in time");
        if (n == lim) timeout("strobe");
        if (!external_timebase_mode) chk(32'(window), 32'h1, "window open");
        @(posedge clk_i);
        chk(32'(strobe), 32'h0, "strobe one cycle");
        repeat (10) @(posedge clk_i);
        chk(32'(window), 32'h0, "window closed");
        rdt(ADDR_IRQ_STATUS);
        chk(rd & 32'h7, 32'h4, "trigger flagged");
        if (!external_timebase_mode) begin
            wr(ADDR_IRQ_STATUS, 32'h7, 4'hf);
            wr(ADDR_CONTROL, 32'h2, 4'hf);
            rdt(ADDR_IRQ_STATUS);
            chk(rd & 32'h7, 32'h4, "software trigger");
        end
    endtask : t_trig
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_boot();
        t_nvm();
        t_bad();
        t_trig(1'b0, 8);
        t_trig(1'b1, EXTERNAL_TIMEBASE_MODE_JITTER + 12);
        summarize();
    end
endmodule : tb_nvm_access_trigger
